// ### logic/dac_vol_regs.svh
// Register offsets, field reset values and frame-count constants.
`ifndef DAC_VOL_REGS_SVH
`define DAC_VOL_REGS_SVH
`define DVC_ADDR_CTRL 8'h00
`define DVC_ADDR_STATUS 8'h04
`define DVC_ADDR_LEVEL0 8'h20
`define DVC_ADDR_LEVEL7 8'h3C
`define DVC_CTRL_RESET 18'h0_0302
`define DVC_CODE_RESET 8'h00
`define DVC_CODE_MUTE 8'h7F
`define DVC_CODE_STEP 11'd14
`define DVC_LEVEL_FULL 11'd1792
`define DVC_STEP_SLOW 11'd1
`define DVC_STEP_MID 11'd2
`define DVC_STEP_FAST 11'd7
`define DVC_ZERO_FRAMES 8192
`define DVC_ADC_INIT_FRAMES 522
`define DVC_WAKE_LOW_FRAMES 4'd10
`define DVC_SR_OFF_FRAMES 3'd4
`define DVC_SR_WAKE_FRAMES 3'd6
`endif

// ### logic/dac_vol_pkg.sv
// Types shared by the volume, mute and power control block.
package dac_vol_pkg;
  typedef logic [10:0] level_t;
  typedef struct packed {
    logic [7:0] group_two_map;
    logic dac_power_bit;
    logic adc_power_bit;
    logic [3:0] dac_pair_powerdown;
    logic [1:0] ramp_speed_select;
    logic soft_reset_bit;
    logic soft_mute_control;
  } ctrl_t;
  typedef struct packed {
    logic [3:0] dac_pair_park;
    logic dac_power_down;
    logic adc_power_down;
  } power_t;
  typedef enum logic [1:0] {SR_RUN, SR_DELAY, SR_OFF, SR_WAKE} sr_state_t;
endpackage

// ### logic/dac_volume_mute_power_control.sv
// Eight-channel DAC volume ramp, soft mute, zero flags and power sequencing.
`timescale 1ns/10ps
`include "dac_vol_regs.svh"
// Functional notes
// - Each channel has an 8-bit code, 0.5 dB steps, 7F and above mute.
// - Ramp speed select gives 1792, 896 or 256 sample periods.
// - Code changes ramp gradually through 1792 fine levels at slowest speed.
// - Power-down pin low resets every channel code to zero.
// - Soft reset holds level at 0 dB, then ramps to stored codes.
// - Soft mute ramps every channel from current level to full mute.
// - Mute release ramps back at same rate, reversing mid-ramp.
// - Group zero flag rises after 8192 zero frames, drops on nonzero.
// - Timing starts on frame clock rising edge after power-down ends.
// - Power-down pin low resets registers, filters, flags low.
// - ADC output is zero for 522 frames after leaving power-down.
// - Individual power bits keep registers; ADC power off forces output low.
// - DAC power bit off parks outputs and drives both flags high.
// - Both flags stay low 10 to 11 frames after power-down release.
// - Soft reset powers down converters, ADC low, flags high, keeps registers.
// - Soft reset entry takes effect after 4 to 5 frames.
// - Flags follow zero detection again 6 to 7 frames after soft reset release.
// - Pair power-down parks only that pair's analog part.
// - Powered-down pairs are left out of both zero flags.
// - Mute register bit and mute pin are combined by OR.
// - Soft reset restarts internal timing, flags high, registers kept; running_reg and wake_cnt_reg are not reset by it.
module dac_volume_mute_power_control #(
  parameter int ZERO_FRAMES = `DVC_ZERO_FRAMES,
  parameter int ADC_INIT_FRAMES = `DVC_ADC_INIT_FRAMES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic power_down_pin_n_i,
  input wire logic frame_clock_i,
  input wire logic soft_mute_pin_i,
  input wire logic [7:0] zero_in_i,
  input wire logic [23:0] adc_sample_i,
  output logic [23:0] adc_serial_out_o,
  output dac_vol_pkg::level_t [7:0] gain_level_o,
  output dac_vol_pkg::power_t power_o,
  output logic zero_flag_one_o,
  output logic zero_flag_two_o
);
  import dac_vol_pkg::*;

  localparam int ZW = $clog2(ZERO_FRAMES + 1);

  // ***************************************************************
  // Pin synchronisers and frame clock edge
  // ***************************************************************
  logic [1:0] pwr_sync_reg;
  logic [1:0] mute_sync_reg;
  logic [2:0] frame_sync_reg;
  logic pwr_on;
  logic frame_tick;
  logic mute_eff;
  ctrl_t ctrl_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_sync_reg <= 2'b00;
      mute_sync_reg <= 2'b00;
      frame_sync_reg <= 3'b000;
    end else begin
      pwr_sync_reg <= {pwr_sync_reg[0], power_down_pin_n_i};
      mute_sync_reg <= {mute_sync_reg[0], soft_mute_pin_i};
      frame_sync_reg <= {frame_sync_reg[1:0], frame_clock_i};
    end
  end

  assign pwr_on = pwr_sync_reg[1];
  assign frame_tick = frame_sync_reg[1] & ~frame_sync_reg[2];
  assign mute_eff = ctrl_reg.soft_mute_control | mute_sync_reg[1];

  // ***************************************************************
  // Wishbone register file
  // ***************************************************************
  logic [7:0] code_reg [8];
  logic [31:0] rd_data;
  logic wb_req;
  sr_state_t sr_state_reg;
  logic running_reg;
  logic [9:0] adc_cnt_reg;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
      input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (dat & m);
  endfunction

  function automatic logic is_level_addr(input logic [7:0] a);
    return a >= `DVC_ADDR_LEVEL0 && a <= `DVC_ADDR_LEVEL7 && a[1:0] == 2'b00;
  endfunction

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // Writes are dropped while the power-down pin is low.
  always_ff @(posedge clk_i) begin
    if (rst_i || !pwr_on) begin
      ctrl_reg <= ctrl_t'(`DVC_CTRL_RESET);
    end else if (wb_req && wb_we_i && wb_adr_i == `DVC_ADDR_CTRL) begin
      ctrl_reg <= ctrl_t'(merge_bytes({14'h0000, ctrl_reg}, wb_dat_i,
                                      wb_sel_i));
    end
  end

  generate
    for (genvar c = 0; c < 8; c++) begin : g_code
      always_ff @(posedge clk_i) begin
        if (rst_i || !pwr_on) begin
          code_reg[c] <= `DVC_CODE_RESET;
        end else if (wb_req && wb_we_i && wb_sel_i[0] &&
                     is_level_addr(wb_adr_i) && wb_adr_i[4:2] == 3'(c)) begin
          code_reg[c] <= wb_dat_i[7:0];
        end
      end
    end
  endgenerate

  always_comb begin
    rd_data = 32'h0000_0000;
    if (wb_adr_i == `DVC_ADDR_CTRL) begin
      rd_data = {14'h0000, ctrl_reg};
    end else if (wb_adr_i == `DVC_ADDR_STATUS) begin
      rd_data = {24'h00_0000, zero_flag_two_o, zero_flag_one_o,
                 sr_state_reg, running_reg,
                 adc_cnt_reg == 10'(ADC_INIT_FRAMES), mute_eff, pwr_on};
    end else if (is_level_addr(wb_adr_i)) begin
      rd_data = {24'h00_0000, code_reg[wb_adr_i[4:2]]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req && !wb_we_i ? rd_data : 32'h0000_0000;
    end
  end

  // ***************************************************************
  // Internal timing and soft reset sequence
  // ***************************************************************
  logic [3:0] wake_cnt_reg;
  logic [2:0] sr_cnt_reg;
  logic sr_on;

  // The frame clock may stop in soft reset, so leaving the off state
  // waits on the register bit alone.
  always_ff @(posedge clk_i) begin
    if (rst_i || !pwr_on) begin
      running_reg <= 1'b0;
      wake_cnt_reg <= 4'd0;
    end else if (frame_tick) begin
      running_reg <= 1'b1;
      if (running_reg && wake_cnt_reg != `DVC_WAKE_LOW_FRAMES) begin
        wake_cnt_reg <= wake_cnt_reg + 4'd1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !pwr_on) begin
      sr_state_reg <= SR_RUN;
      sr_cnt_reg <= 3'd0;
    end else begin
      unique case (sr_state_reg)
        SR_RUN: begin
          sr_cnt_reg <= 3'd0;
          if (!ctrl_reg.soft_reset_bit) begin
            sr_state_reg <= SR_DELAY;
          end
        end
        SR_DELAY: begin
          if (frame_tick) begin
            sr_cnt_reg <= sr_cnt_reg + 3'd1;
            if (sr_cnt_reg == `DVC_SR_OFF_FRAMES - 3'd1) begin
              sr_state_reg <= SR_OFF;
            end
          end
        end
        SR_OFF: begin
          sr_cnt_reg <= 3'd0;
          if (ctrl_reg.soft_reset_bit) begin
            sr_state_reg <= SR_WAKE;
          end
        end
        SR_WAKE: begin
          if (frame_tick) begin
            sr_cnt_reg <= sr_cnt_reg + 3'd1;
            if (sr_cnt_reg == `DVC_SR_WAKE_FRAMES - 3'd1) begin
              sr_state_reg <= SR_RUN;
            end
          end
        end
      endcase
    end
  end

  assign sr_on = sr_state_reg == SR_RUN || sr_state_reg == SR_DELAY ||
                 sr_state_reg == SR_WAKE;

  // ***************************************************************
  // ADC output gating
  // ***************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i || !pwr_on || !sr_on || !running_reg) begin
      adc_cnt_reg <= 10'd0;
    end else if (frame_tick && adc_cnt_reg != 10'(ADC_INIT_FRAMES)) begin
      adc_cnt_reg <= adc_cnt_reg + 10'd1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_reg.adc_power_bit || !sr_on ||
        adc_cnt_reg != 10'(ADC_INIT_FRAMES)) begin
      adc_serial_out_o <= 24'h00_0000;
    end else begin
      adc_serial_out_o <= adc_sample_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_o <= '1;
    end else begin
      power_o.adc_power_down <= !pwr_on || !sr_on ||
                                !ctrl_reg.adc_power_bit;
      power_o.dac_power_down <= !pwr_on || !sr_on ||
                                !ctrl_reg.dac_power_bit;
      for (int p = 0; p < 4; p++) begin
        power_o.dac_pair_park[p] <= !pwr_on || !sr_on ||
            !ctrl_reg.dac_power_bit ||
            ctrl_reg.dac_pair_powerdown[p];
      end
    end
  end

  // ***************************************************************
  // Attenuation ramps
  // ***************************************************************
  function automatic level_t code_target(input logic [7:0] code);
    if (code >= `DVC_CODE_MUTE) begin
      return `DVC_LEVEL_FULL;
    end
    return {3'b000, code} * `DVC_CODE_STEP;
  endfunction

  function automatic level_t speed_step(input logic [1:0] sel);
    unique case (sel)
      2'b00: return `DVC_STEP_SLOW;
      2'b01: return `DVC_STEP_MID;
      default: return `DVC_STEP_FAST;
    endcase
  endfunction

  level_t step;
  assign step = speed_step(ctrl_reg.ramp_speed_select);

  generate
    for (genvar c = 0; c < 8; c++) begin : g_ramp
      level_t target;
      logic [11:0] up_sum;
      assign target = mute_eff ? `DVC_LEVEL_FULL :
                      code_target(code_reg[c]);
      assign up_sum = {1'b0, gain_level_o[c]} + {1'b0, step};
      always_ff @(posedge clk_i) begin
        if (rst_i || !pwr_on || !sr_on) begin
          gain_level_o[c] <= '0;
        end else if (frame_tick && gain_level_o[c] < target) begin
          gain_level_o[c] <= up_sum > {1'b0, target} ? target :
                             up_sum[10:0];
        end else if (frame_tick && gain_level_o[c] > target) begin
          gain_level_o[c] <= gain_level_o[c] - target < step ? target :
                             gain_level_o[c] - step;
        end
      end
    end
  endgenerate

  // ***************************************************************
  // Zero detection
  // ***************************************************************
  logic [ZW-1:0] zero_cnt_reg [8];
  logic [7:0] ch_zero;
  logic [7:0] counted;
  logic grp_one_zero;
  logic grp_two_zero;

  generate
    for (genvar c = 0; c < 8; c++) begin : g_zero
      always_ff @(posedge clk_i) begin
        if (rst_i || !pwr_on || !zero_in_i[c]) begin
          zero_cnt_reg[c] <= '0;
        end else if (frame_tick && zero_cnt_reg[c] != ZW'(ZERO_FRAMES)) begin
          zero_cnt_reg[c] <= zero_cnt_reg[c] + ZW'(1);
        end
      end
      assign ch_zero[c] = zero_in_i[c] &&
                          zero_cnt_reg[c] == ZW'(ZERO_FRAMES);
      assign counted[c] = !ctrl_reg.dac_pair_powerdown[c / 2];
    end
  endgenerate

  assign grp_one_zero = &(ch_zero | ~counted | ctrl_reg.group_two_map);
  assign grp_two_zero = &(ch_zero | ~counted | ~ctrl_reg.group_two_map);

  always_ff @(posedge clk_i) begin
    if (rst_i || !pwr_on) begin
      zero_flag_one_o <= 1'b0;
      zero_flag_two_o <= 1'b0;
    end else if (sr_state_reg != SR_RUN) begin
      zero_flag_one_o <= 1'b1;
      zero_flag_two_o <= 1'b1;
    end else if (wake_cnt_reg != `DVC_WAKE_LOW_FRAMES) begin
      zero_flag_one_o <= 1'b0;
      zero_flag_two_o <= 1'b0;
    end else if (!ctrl_reg.dac_power_bit) begin
      zero_flag_one_o <= 1'b1;
      zero_flag_two_o <= 1'b1;
    end else begin
      zero_flag_one_o <= grp_one_zero;
      zero_flag_two_o <= grp_two_zero;
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_pdn_flags_low: assert property (
    !pwr_on |=> !zero_flag_one_o && !zero_flag_two_o)
    else $error("zero flags not low in power-down");
  a_pdn_level_clear: assert property (
    !pwr_on |=> code_reg[0] == 8'h00 && gain_level_o[3] == 11'd0)
    else $error("code or level not cleared in power-down");
  a_sr_flags_high: assert property (
    pwr_on && sr_state_reg == SR_OFF |=> zero_flag_one_o && zero_flag_two_o)
    else $error("zero flags not high in soft reset");
  a_sr_level_hold: assert property (
    pwr_on && sr_state_reg == SR_OFF ##1 pwr_on |-> gain_level_o[1] == 11'd0)
    else $error("level not held at zero in soft reset");
  a_adc_power_low: assert property (
    !ctrl_reg.adc_power_bit |=> adc_serial_out_o == 24'h00_0000)
    else $error("adc output not low with adc power off");
  a_adc_init_zero: assert property (
    adc_cnt_reg != 10'(ADC_INIT_FRAMES) |=> adc_serial_out_o == 24'h00_0000)
    else $error("adc output not zero during initialisation");
  a_ramp_step_size: assert property (
    pwr_on && sr_on && $past(pwr_on) && $past(sr_on) |->
    gain_level_o[0] - $past(gain_level_o[0]) <= `DVC_STEP_FAST ||
    $past(gain_level_o[0]) - gain_level_o[0] <= `DVC_STEP_FAST)
    else $error("ramp jumped more than one step");
  a_mute_ramps_down: assert property (
    pwr_on && sr_on && mute_eff && frame_tick &&
    gain_level_o[2] < `DVC_LEVEL_FULL ##1 pwr_on && sr_on |->
    gain_level_o[2] > $past(gain_level_o[2]))
    else $error("mute does not raise attenuation");
  a_level_in_range: assert property (
    gain_level_o[4] <= `DVC_LEVEL_FULL)
    else $error("level beyond full mute");
  a_sr_entry_delay: assert property (
    sr_state_reg == SR_RUN && pwr_on && !ctrl_reg.soft_reset_bit |=>
    sr_state_reg == SR_DELAY [*2])
    else $error("soft reset took effect without delay");

  c_mute_full: cover property (mute_eff && gain_level_o[0] == 11'd1792);
  c_soft_reset_cycle: cover property (sr_state_reg == SR_WAKE ##1
                                      sr_state_reg == SR_RUN);
  c_zero_flag_one: cover property (zero_flag_one_o && sr_state_reg == SR_RUN);
  c_adc_valid: cover property (adc_serial_out_o != 24'h00_0000);
endmodule

// ### sim/frame_source_model.sv
// Host-side model that supplies the frame clock to the volume block.
`timescale 1ns/10ps
module frame_source_model #(
  parameter real HALF_NS = 100.0
) (
  input wire logic run_i,
  output logic frame_clock_o
);
  // The phase offset keeps frame edges off the system clock edges.
  initial begin
    frame_clock_o = 1'b0;
    #37.0;
    forever begin
      #(HALF_NS);
      // Stopping is allowed only in soft reset; it always parks low.
      if (run_i || frame_clock_o) begin
        frame_clock_o = ~frame_clock_o;
      end
    end
  end
endmodule

// ### sim/dac_volume_mute_power_control_test.sv
// Self-checking bench for the volume, mute and power control block.
`timescale 1ns/10ps
module dac_volume_mute_power_control_test;
  import dac_vol_pkg::*;
  typedef struct {int what; logic [31:0] val;} note_t;
  logic clk_i, rst_i, cyc, stb, we, ack, pin_n, fclk, mute_pin, zf1, zf2;
  logic run, probe;
  logic [7:0] adr, zero_in;
  logic [31:0] wdat, rdat, got, dummy;
  logic [23:0] adc_in, adc_out;
  level_t [7:0] gain;
  power_t pwr;
  note_t notes[$];
  note_t nt;
  int err_total, check_count, cur, t, stp;
  logic [7:0] code [8];
  logic [7:0] tgt;

  // ***************************************************************
  // Design, partner and clock
  // ***************************************************************
  dac_volume_mute_power_control #(.ZERO_FRAMES(16), .ADC_INIT_FRAMES(20))
  uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .power_down_pin_n_i(pin_n),
    .frame_clock_i(fclk), .soft_mute_pin_i(mute_pin),
    .zero_in_i(zero_in), .adc_sample_i(adc_in),
    .adc_serial_out_o(adc_out), .gain_level_o(gain), .power_o(pwr),
    .zero_flag_one_o(zf1), .zero_flag_two_o(zf2));
  frame_source_model src (.run_i(run), .frame_clock_o(fclk));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ***************************************************************
  // Tasks
  // ***************************************************************
  function automatic logic [10:0] lvl(input logic [7:0] c);
    lvl = (c >= 8'h7f) ? 11'h700 : 11'(c) * 11'h00e;
  endfunction
  function automatic logic [31:0] obs(input int what);
    case (what)
      9: obs = {30'h0, zf2, zf1};
      10: obs = {8'h0, adc_out};
      11: obs = {26'h0, pwr};
      12: obs = {31'h0, gain[0] > 11'h000 && gain[0] < 11'h700};
      13: obs = {30'h0, pwr.dac_power_down, pwr.adc_power_down};
      default: obs = {21'h0, gain[what - 1]};
    endcase
  endfunction
  task automatic tk(input int n);
    repeat (n * 8) @(posedge clk_i);
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    if (!w) begin
      notes.push_back('{0, d});
    end
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic chk(input int what, input logic [31:0] v);
    notes.push_back('{what, v});
    probe <= 1'b1;
    @(posedge clk_i);
    probe <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ***************************************************************
  // Result watcher
  // ***************************************************************
  always @(posedge clk_i) begin
    if ((ack === 1'b1 && we === 1'b0) || probe === 1'b1) begin
      nt = notes.pop_front();
      got = (nt.what == 0) ? rdat : obs(nt.what);
      check_count++;
      if (got !== nt.val) begin
        err_total++;
        $display("CHECK FAILED at %0t: expected %h got %h", $time,
          nt.val, got);
      end
    end
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    err_total++;
    finish_test();
  end

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    dummy = $urandom(32'h03bb179e);
    {rst_i, cyc, stb, we, adr, wdat, mute_pin, pin_n, probe} = '0;
    run = 1'b1;
    zero_in = 8'hff;
    adc_in = 24'($urandom);
    for (int c = 0; c < 8; c++) begin
      code[c] = (c < 2) ? 8'h7e + 8'(c) : 8'($urandom_range(255, 0));
    end
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    tk(2);
    pin_n <= 1'b1;
    wb(0, 8'h00, 32'h0000_0302);
    wb(0, 8'h2c, 32'h0000_0000);
    wb(0, 8'h80, 32'h0000_0000);
    wb(1, 8'h00, 32'h0000_0102);
    tk(2);
    chk(9, 0);
    chk(10, 0);
    tk(12);
    chk(9, 3);
    $display("test power-up done");
    wb(1, 8'h00, 32'h0000_0302);
    tk(20);
    chk(9, 3);
    zero_in[3] <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(9, 2);
    wb(1, 8'h00, 32'h0000_2302);
    chk(9, 1);
    wb(1, 8'h00, 32'h0000_0322);
    tk(1);
    chk(9, 3);
    chk(11, 8);
    zero_in[3] <= 1'b1;
    $display("test zero flags done");
    wb(1, 8'h00, 32'h0000_030e);
    for (int c = 0; c < 8; c++) begin
      wb(1, 8'h20 + 8'(4 * c), {24'h0, code[c]});
    end
    tk(260);
    for (int c = 0; c < 8; c++) begin
      chk(c + 1, {21'h0, lvl(code[c])});
      wb(0, 8'h20 + 8'(4 * c), {24'h0, code[c]});
    end
    cur = 1764;
    for (int s = 0; s < 3; s++) begin
      tgt = (s == 1) ? 8'hff : 8'h00;
      stp = (s == 0) ? 1 : (s == 1) ? 2 : 7;
      t = (tgt == 8'hff ? 1792 - cur : cur) / stp;
      wb(1, 8'h00, 32'h0000_0302 | (s << 2));
      wb(1, 8'h20, {24'h0, tgt});
      tk(t * 9 / 10);
      chk(12, 1);
      tk(t / 5 + 4);
      chk(1, {21'h0, lvl(tgt)});
      cur = lvl(tgt);
    end
    $display("test attenuation done");
    wb(1, 8'h00, 32'h0000_030a);
    wb(1, 8'h20, 32'h0000_0010);
    tk(40);
    chk(1, 224);
    mute_pin <= 1'b1;
    tk(240);
    chk(1, 1792);
    mute_pin <= 1'b0;
    tk(240);
    chk(1, 224);
    wb(1, 8'h00, 32'h0000_030b);
    tk(10);
    chk(12, 1);
    wb(1, 8'h00, 32'h0000_030a);
    tk(20);
    chk(1, 224);
    chk(10, {8'h0, adc_in});
    $display("test soft mute done");
    wb(1, 8'h00, 32'h0000_0308);
    chk(9, 3);
    tk(1);
    chk(1, 224);
    tk(6);
    chk(1, 0);
    chk(10, 0);
    chk(13, 3);
    wb(0, 8'h20, 32'h0000_0010);
    wb(1, 8'h00, 32'h0000_03f8);
    run <= 1'b0;
    tk(5);
    run <= 1'b1;
    tk(1);
    wb(1, 8'h00, 32'h0000_030a);
    tk(3);
    chk(9, 3);
    tk(300);
    chk(1, 224);
    $display("test soft reset done");
    wb(1, 8'h00, 32'h0000_020a);
    tk(1);
    chk(10, 0);
    wb(0, 8'h20, 32'h0000_0010);
    pin_n <= 1'b0;
    tk(1);
    wb(1, 8'h20, 32'h0000_0055);
    chk(9, 0);
    chk(1, 0);
    wb(0, 8'h20, 32'h0000_0000);
    wb(0, 8'h00, 32'h0000_0302);
    $display("test power-down done");
    finish_test();
  end
endmodule
